// file: hdl/srcfg_regs.svh
`ifndef SRCFG_REGS_SVH
`define SRCFG_REGS_SVH
// Scheme codes, two bits wide
`define SRCFG_SCH_THREE 2'h0
`define SRCFG_SCH_LR1 2'h1
`define SRCFG_SCH_LR2 2'h2
`define SRCFG_SCH_R1R2 2'h3
// Settle and power-up waits, in microseconds
`define SRCFG_WAIT_US 1000000
`define SRCFG_CLK_MHZ 20
`define SRCFG_WAIT_CYC (`SRCFG_WAIT_US * `SRCFG_CLK_MHZ)
`define SRCFG_CNT_W 25
`endif

// file: hdl/srcfg_pkg.sv
package srcfg_pkg;
  // Scheme setting, encoded as the SRCFG_SCH_* codes
  typedef logic [1:0] srcfg_scheme_t;
  // Channel status and remote configuration commands
  typedef struct packed {
    logic ch1_ok;
    logic ch2_ok;
    logic rx1_valid;
    logic rx2_valid;
    srcfg_scheme_t rx1_cmd;
    srcfg_scheme_t rx2_cmd;
  } srcfg_link_t;
  // Controller states
  typedef enum logic [2:0] {
    SRCFG_PWRUP,
    SRCFG_IDLE,
    SRCFG_SETTLE,
    SRCFG_CHECK
  } srcfg_state_t;
endpackage : srcfg_pkg

// file: hdl/srcfg_timer.sv
`timescale 1ns/1ps
`include "srcfg_regs.svh"
// One-second wait timer, restartable
module srcfg_timer #(
  parameter int unsigned WAIT_CYC = `SRCFG_WAIT_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  output logic done
);
  // Remaining cycles; zero means idle
  logic [`SRCFG_CNT_W-1:0] cnt_q;
  logic [`SRCFG_CNT_W-1:0] cnt_d;
  logic done_q;
  wire logic running = (cnt_q != '0);
  // Restart wins over a running count
  assign cnt_d = start ? WAIT_CYC[`SRCFG_CNT_W-1:0] :
                 running ? cnt_q - 1'b1 : cnt_q;
  // Counter and single-cycle done pulse
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= !start && (cnt_q == {{(`SRCFG_CNT_W-1){1'b0}}, 1'b1});
    end
  end
  assign done = done_q;
endmodule : srcfg_timer

// file: hdl/srcfg_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pin-level inputs
module srcfg_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // First stage feeds only the second
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end
  assign dout = s2_q;
endmodule : srcfg_sync

// file: hdl/srcfg_ctrl.sv
`timescale 1ns/1ps
`include "srcfg_regs.svh"
module srcfg_ctrl (
  input wire logic mclk,
  input wire logic rst,
  // Relay configuration and the user's scheme request
  input wire logic three_term_mode,
  input wire srcfg_pkg::srcfg_scheme_t setting,
  // Scheme kept from before power-down
  input wire srcfg_pkg::srcfg_scheme_t nv_scheme,
  // Interlock pins, asynchronous
  input wire logic inhibit_diff_pin,
  input wire logic permit_pin,
  // Channel health and commands from both remotes
  input wire srcfg_pkg::srcfg_link_t link,
  // Trip requests from the differential and backup elements
  input wire logic diff_trip_req,
  input wire logic backup_trip_req,
  // Trip pin and scheme status
  output logic trip_out,
  output srcfg_pkg::srcfg_scheme_t active_scheme,
  output srcfg_pkg::srcfg_scheme_t stored_scheme_setting,
  // Command to both remotes
  output logic tx_cmd_valid,
  output srcfg_pkg::srcfg_scheme_t tx_cmd,
  // Alarm and activity
  output logic config_error,
  output logic busy
);
  import srcfg_pkg::*;

  // Flow in brief: after reset the controller sits in power-up until
  // the remotes speak or the one-second wait runs out, then idles.
  // In idle it watches the user setting for a change; a legal change
  // sends a command to both remotes, starts the settle wait and the
  // live scheme moves at once, so protection runs on the new layout
  // while the remotes catch up. The check after the wait either keeps
  // the move and updates the stored setting, or falls back and raises
  // the sticky alarm. While three_term_mode is low nothing new is taken; a request already in flight still runs to its check.
  // Limitations: requests are level changes of the setting, not
  // strobes, and only the value seen on the return to idle counts;
  // power-up takes the first cycle in which a remote is heard without conflict, and
  // later traffic is handled by the follow logic in idle.

  // Synchronised interlock pins
  // Both interlocks come from outside the clock domain, so they pass
  // two flops; the lag means a request must hold its interlocks a few
  // cycles before the setting moves. Trip gating uses the same copy.
  logic [1:0] ilk_s;
  srcfg_sync #(.W(2)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din({inhibit_diff_pin, permit_pin}),
    .dout(ilk_s)
  );
  wire logic inhibit_diff = ilk_s[1];
  wire logic permit = ilk_s[0];

  // Registered state
  // Target and fallback are captured at the request and held until
  // the check, so the user may move the setting during the wait.
  srcfg_state_t state_q, state_d;
  srcfg_scheme_t act_q, act_d; // Live scheme
  srcfg_scheme_t sto_q, sto_d; // Stored setting
  srcfg_scheme_t tgt_q, tgt_d; // Requested target
  srcfg_scheme_t prev_q, prev_d; // Scheme to fall back to
  srcfg_scheme_t set_q; // Last seen setting, for change detect
  logic err_q, err_d;
  logic txv_q, txv_d;
  srcfg_scheme_t txc_q, txc_d;
  logic trip_q; // Gated trip, registered so the pin never glitches
  logic seen_q; // Set once power-up has ended, by message, timeout or mode
  logic busy_q; // Not idle, kept in a flop like every other output

  // Timer, restarted per request or at power-up
  // One shared counter serves both waits: they never overlap, as a
  // request is only taken once power-up has ended, and a restart
  // cancels any pulse still pending from the power-up wait.
  // The done pulse lasts one cycle and is only looked at in power-up
  // and settle.
  logic tmr_start;
  logic tmr_done;
  srcfg_timer u_timer (
    .mclk(mclk),
    .rst(rst),
    .start(tmr_start),
    .done(tmr_done)
  );
  logic pwr_start_q; // One pulse after reset release

  // Is a code two-ended
  // Every code but three-ended names a pair of ends
  function automatic logic is_two(input srcfg_scheme_t s);
    return s != `SRCFG_SCH_THREE;
  endfunction : is_two

  // Channel needed for each two-ended target
  // The remote pair and a full restore are judged on both channels
  function automatic logic chans_ok(input srcfg_scheme_t s,
                                    input srcfg_link_t l);
    unique case (s)
      `SRCFG_SCH_THREE: return l.ch1_ok && l.ch2_ok;
      `SRCFG_SCH_LR1: return l.ch1_ok;
      `SRCFG_SCH_LR2: return l.ch2_ok;
      `SRCFG_SCH_R1R2: return l.ch1_ok && l.ch2_ok;
    endcase
  endfunction : chans_ok

  // Merge two remote commands
  // Channel one is looked at first only to pick between two agreeing
  // two-ended commands; a disagreement is caught separately below.
  wire logic both_rx = link.rx1_valid && link.rx2_valid;
  wire logic any_rx = link.rx1_valid || link.rx2_valid;
  wire logic rx_conflict = both_rx && is_two(link.rx1_cmd) &&
    is_two(link.rx2_cmd) && (link.rx1_cmd != link.rx2_cmd);
  // Two-ended wins unless both say three-ended
  wire srcfg_scheme_t rx_merged =
    (link.rx1_valid && is_two(link.rx1_cmd)) ? link.rx1_cmd :
    (link.rx2_valid && is_two(link.rx2_cmd)) ? link.rx2_cmd :
    `SRCFG_SCH_THREE;
  // Remote view after settle: agrees with target
  // A silent remote counts against a settle only when neither speaks;
  // one quiet channel alone is judged by the channel-health term.
  wire logic settled = both_rx ? (!rx_conflict && rx_merged == tgt_q)
                       : (any_rx && rx_merged == tgt_q);

  // A setting move is a request only in three-terminal use
  wire logic set_change = (setting != set_q) && three_term_mode;
  // Idle follows remote traffic only once power-up has handed over
  wire logic rx_live = seen_q && three_term_mode;
  wire logic ilk_ok = inhibit_diff && permit;

  // Next-state logic
  // Defaults hold every register; the command strobe is the only
  // value that drops back on its own, giving a one-cycle pulse.
  // The timer start defaults to the power-up kick after reset.
  always_comb begin
    state_d = state_q;
    act_d = act_q;
    sto_d = sto_q;
    tgt_d = tgt_q;
    prev_d = prev_q;
    err_d = err_q;
    txv_d = 1'b0;
    txc_d = txc_q;
    tmr_start = pwr_start_q;
    unique case (state_q)
      // Wait for first messages or the one-second timeout
      SRCFG_PWRUP: begin
        if (!three_term_mode) begin
          // Not a three-terminal relay: nothing to negotiate
          state_d = SRCFG_IDLE;
        end else if (any_rx && !rx_conflict) begin
          act_d = rx_merged;
          state_d = SRCFG_IDLE;
        end else if (tmr_done) begin
          act_d = nv_scheme;
          state_d = SRCFG_IDLE;
        end
      end
      // Take one request at a time; remote traffic only when none
      SRCFG_IDLE: begin
        if (set_change) begin
          if (is_two(act_q) && is_two(setting)) begin
            // Pair to pair must pass through three-ended first
            err_d = 1'b1;
          end else if (is_two(act_q) != is_two(setting)) begin
            prev_d = act_q;
            tgt_d = setting;
            if ((!is_two(setting) && chans_ok(setting, link)) ||
                (is_two(setting) && ilk_ok &&
                 chans_ok(setting, link))) begin
              txv_d = 1'b1;
              txc_d = setting;
              act_d = setting;
              tmr_start = 1'b1;
              state_d = SRCFG_SETTLE;
            end else begin
              // Refused before anything was sent: scheme unchanged
              err_d = 1'b1;
            end
          end
        end else if (rx_live && rx_conflict) begin
          // Remotes disagree: no way to choose, so hold and alarm
          err_d = 1'b1;
        end else if (rx_live && any_rx && rx_merged != act_q) begin
          // Follow what the remotes now say
          act_d = rx_merged;
        end
      end
      // One second after sending, judge the outcome
      // The live scheme already shows the target here, so the wider
      // relay runs on the new layout during the wait.
      SRCFG_SETTLE: begin
        // Remote answers during the wait are not acted on yet
        if (tmr_done) begin
          state_d = SRCFG_CHECK;
        end
      end
      SRCFG_CHECK: begin
        // Channels are judged again here, not only at the request, as
        // a link may drop during the wait
        state_d = SRCFG_IDLE;
        if (settled && chans_ok(tgt_q, link)) begin
          sto_d = tgt_q;
          err_d = 1'b0;
        end else begin
          act_d = prev_q;
          err_d = 1'b1;
        end
      end
      default: state_d = SRCFG_IDLE;
    endcase
  end

  // State registers; three-ended by default at reset
  // Three-ended is the safe guess when all ends start together
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= SRCFG_PWRUP;
      act_q <= `SRCFG_SCH_THREE;
      sto_q <= `SRCFG_SCH_THREE;
      tgt_q <= `SRCFG_SCH_THREE;
      prev_q <= `SRCFG_SCH_THREE;
      err_q <= 1'b0;
      txv_q <= 1'b0;
      txc_q <= `SRCFG_SCH_THREE;
      pwr_start_q <= 1'b1; // Kicks the power-up wait on release
      busy_q <= 1'b1; // Power-up counts as busy
    end else begin
      state_q <= state_d;
      act_q <= act_d;
      sto_q <= sto_d;
      tgt_q <= tgt_d;
      prev_q <= prev_d;
      err_q <= err_d;
      txv_q <= txv_d;
      txc_q <= txc_d;
      pwr_start_q <= 1'b0;
      busy_q <= (state_d != SRCFG_IDLE);
    end
  end

  // Setting change tracking; first sample taken after reset
  // The copy is frozen while a request is in flight, so a move made
  // during the wait is seen as a fresh request once idle again. A
  // setting that returns to its old value in the meantime is lost.
  wire logic set_track = (state_q == SRCFG_PWRUP) ||
    (state_q == SRCFG_IDLE);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      set_q <= `SRCFG_SCH_THREE;
      seen_q <= 1'b0;
    end else begin
      set_q <= set_track ? setting : set_q;
      seen_q <= seen_q || (state_q != SRCFG_PWRUP);
    end
  end

  // Inhibit masks differential trip only
  // Backup functions keep their path to the trip output whatever the
  // interlocks say, so an isolated end stays protected. The mask
  // follows the pin two cycles late, through the synchroniser.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trip_q <= 1'b0;
    end else begin
      trip_q <= (diff_trip_req && !inhibit_diff) || backup_trip_req;
    end
  end

  // Outputs, each straight from its flop
  assign trip_out = trip_q;
  assign active_scheme = act_q;
  assign stored_scheme_setting = sto_q;
  assign tx_cmd_valid = txv_q;
  assign tx_cmd = txc_q;
  assign config_error = err_q;
  assign busy = busy_q;
endmodule : srcfg_ctrl

// file: test/srcfg_chk_assertions.sv
`timescale 1ns/1ps
// Port-level checks on the scheme controller
module srcfg_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic inhibit_diff_pin,
  input wire logic permit_pin,
  input wire srcfg_pkg::srcfg_link_t link,
  input wire logic backup_trip_req,
  input wire logic trip_out,
  input wire srcfg_pkg::srcfg_scheme_t active_scheme,
  input wire srcfg_pkg::srcfg_scheme_t stored_scheme_setting,
  input wire logic tx_cmd_valid,
  input wire srcfg_pkg::srcfg_scheme_t tx_cmd,
  input wire logic config_error,
  input wire logic busy
);
  import srcfg_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_bkp; backup_trip_req |=> trip_out; endproperty
  a_bkp: assert property (p_bkp) else $error("backup trip lost");
  property p_inh;
    inhibit_diff_pin [*4] ##0 !backup_trip_req |=> !trip_out;
  endproperty
  a_inh: assert property (p_inh) else $error("diff trip leaked");
  property p_two;
    tx_cmd_valid && tx_cmd != 2'h0 |-> $past(active_scheme) == 2'h0;
  endproperty
  a_two: assert property (p_two) else $error("two to two sent");
  property p_ilk;
    tx_cmd_valid && tx_cmd != 2'h0 |->
      $past(permit_pin, 3) && $past(inhibit_diff_pin, 3);
  endproperty
  a_ilk: assert property (p_ilk) else $error("interlock ignored");
  property p_ch1;
    tx_cmd_valid && tx_cmd == 2'h1 |-> $past(link.ch1_ok);
  endproperty
  a_ch1: assert property (p_ch1) else $error("channel one down");
  property p_all;
    tx_cmd_valid && tx_cmd == 2'h0 |-> $past(link.ch1_ok && link.ch2_ok);
  endproperty
  a_all: assert property (p_all) else $error("restore on bad link");
  property p_hold; tx_cmd_valid |-> busy [*8]; endproperty
  a_hold: assert property (p_hold) else $error("settle cut short");
  property p_rev;
    $fell(busy) && config_error |->
      active_scheme != $past(active_scheme);
  endproperty
  a_rev: assert property (p_rev) else $error("no revert on error");
  property p_clr; $fell(config_error) |-> $past(busy); endproperty
  a_clr: assert property (p_clr) else $error("alarm cleared idle");
endmodule : srcfg_chk
bind srcfg_ctrl srcfg_chk u_chk (
  .mclk(mclk),
  .rst(rst),
  .inhibit_diff_pin(inhibit_diff_pin),
  .permit_pin(permit_pin),
  .link(link),
  .backup_trip_req(backup_trip_req),
  .trip_out(trip_out),
  .active_scheme(active_scheme),
  .stored_scheme_setting(stored_scheme_setting),
  .tx_cmd_valid(tx_cmd_valid),
  .tx_cmd(tx_cmd),
  .config_error(config_error),
  .busy(busy)
);

// file: test/srcfg_remote.sv
`timescale 1ns/1ps
// Both remote relays as seen over their channels
module srcfg_remote (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tx_cmd_valid,
  input wire srcfg_pkg::srcfg_scheme_t tx_cmd,
  input wire logic en,
  input wire logic obey,
  input wire logic ch_ok,
  input wire logic slow,
  input wire logic skew,
  output srcfg_pkg::srcfg_link_t link
);
  import srcfg_pkg::*;
  srcfg_scheme_t cmd_q, pend_q, tog_q; // Reported, pending, noise
  logic [3:0] lag_q; // Cycles before the remotes follow
  // Follow a command promptly or slowly, or not when disobeying
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_q <= 2'h0;
      pend_q <= 2'h0;
      lag_q <= 4'h0;
      tog_q <= 2'h0;
    end else begin
      tog_q <= tog_q + 2'h1;
      if (tx_cmd_valid && obey) begin
        pend_q <= tx_cmd;
        lag_q <= slow ? 4'hc : 4'h1;
      end else if (lag_q != 4'h0) begin
        lag_q <= lag_q - 4'h1;
        if (lag_q == 4'h1) cmd_q <= pend_q;
      end
    end
  end
  // A skewed second remote reports the mirror code of the first
  wire srcfg_scheme_t cmd2 = skew ? (cmd_q ^ 2'h3) : cmd_q;
  // Silent remotes leave the command lines wandering
  assign link = {ch_ok, ch_ok, en, en, en ? cmd_q : tog_q,
    en ? cmd2 : ~tog_q};
endmodule : srcfg_remote

// file: test/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the scheme controller
module tb_top;
  import srcfg_pkg::*;
  logic mclk = 0, rst = 1, inh = 0, prm = 0, en = 0, ob = 1, ok = 1;
  logic sl = 0, dt = 0, bt = 0, ttm = 1, sk = 0, trip, txv, err, busy;
  srcfg_scheme_t set = 2'h0, act_s, sto_s, txc;
  srcfg_link_t link;
  int fails = 0, compares = 0, seed = 32'he48d, act = 0, t;
  // Change code: target, interlocks, channels, remotes obey
  logic [4:0] tbl [8] = '{5'h0f, 5'h17, 5'h07, 5'h13, 5'h1e, 5'h0d,
    5'h17, 5'h06};
  defparam DUT.u_timer.WAIT_CYC = 40; // Short wait keeps run brief
  srcfg_ctrl DUT (.mclk(mclk), .rst(rst), .three_term_mode(ttm),
    .setting(set), .nv_scheme(2'h2), .inhibit_diff_pin(inh),
    .permit_pin(prm), .link(link), .diff_trip_req(dt),
    .backup_trip_req(bt), .trip_out(trip), .active_scheme(act_s),
    .stored_scheme_setting(sto_s), .tx_cmd_valid(txv), .tx_cmd(txc),
    .config_error(err), .busy(busy));
  srcfg_remote PEER (.mclk(mclk), .rst(rst), .tx_cmd_valid(txv),
    .tx_cmd(txc), .en(en), .obey(ob), .ch_ok(ok), .slow(sl),
    .skew(sk), .link(link));
  initial forever #25 mclk = ~mclk;
  task automatic chk(input logic [1:0] s, e, input string n);
    compares++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s exp %h saw %h", n, e, s);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Wait for idle, counting command pulses; a hang ends the run
  task automatic idle(output int c);
    c = 0;
    for (int i = 0; i < 300; i++) begin
      @(negedge mclk);
      c += int'(txv);
      if (i > 2 && !busy) return;
    end
    fails++;
    give_verdict();
  endtask : idle
  // One change request against the integer model
  task automatic chg(input int n, il, ck, o);
    int c, rf, gd;
    rf = (act != 0 && n != 0) || (n != 0 && !il) || !ck;
    gd = !rf && o;
    @(negedge mclk);
    inh = 1'(il);
    prm = 1'(il);
    ok = 1'(ck);
    ob = 1'(o);
    sl = 1'($random(seed));
    repeat (4) @(negedge mclk);
    set = 2'(n);
    idle(c);
    chk(2'(c), 2'(!rf), "tx");
    chk(act_s, 2'(gd ? n : act), "act");
    chk(2'(err), 2'(!gd), "err");
    if (gd) chk(sto_s, 2'(n), "sto");
    if (gd) act = n;
  endtask : chg
  // Power-up, change table, then trip gating
  initial begin
    repeat (12) @(negedge mclk);
    rst = 0;
    idle(t);
    chk(act_s, 2'h2, "nv");
    en = 1;
    repeat (4) @(negedge mclk);
    chk(act_s, 2'h0, "rx");
    foreach (tbl[i]) chg(tbl[i][4:3], tbl[i][2], tbl[i][1], tbl[i][0]);
    for (int h = 0; h < 2; h++) begin
      inh = 1'(h);
      repeat (4) @(negedge mclk);
      repeat (20) begin
        {dt, bt} = 2'($random(seed));
        @(negedge mclk);
        chk(2'(trip), 2'((dt && !h) || bt), "trip");
      end
    end
    // Mid-run reset with both remotes heard, the second mirrored
    en = 1;
    sk = 1;
    rst = 1;
    repeat (12) @(negedge mclk);
    rst = 0;
    idle(t);
    chk(act_s, 2'h3, "pwr");
    chk(2'(err), 2'h0, "perr");
    sk = 0;
    repeat (4) @(negedge mclk);
    chk(act_s, 2'h0, "both");
    act = 0;
    chg(1, 1, 1, 1);
    // Remotes now report differing two-ended schemes
    sk = 1;
    repeat (4) @(negedge mclk);
    chk(2'(err), 2'h1, "conf");
    chk(act_s, 2'h1, "hold");
    // Out of three-terminal use a setting move is ignored
    ttm = 0;
    set = 2'h0;
    idle(t);
    chk(2'(t), 2'h0, "ttm");
    chk(act_s, 2'h1, "off");
    give_verdict();
  end
endmodule : tb_top
